// [verilog/nvac_map.vh]
// register offsets, field positions, keys and timing for the nonvolatile access block
`ifndef NVAC_MAP_VH
`define NVAC_MAP_VH
`define NVAC_OFS_FLAG     8'h0c
`define NVAC_OFS_BYTE     8'h9a
`define NVAC_OFS_INDEX    8'h9b
`define NVAC_OFS_CONTROL  8'h9c
`define NVAC_OFS_UNLOCK   8'h9d
`define NVAC_OFS_STATUS   8'h9e
`define NVAC_BIT_RD       0
`define NVAC_BIT_WR       1
`define NVAC_BIT_EN       2
`define NVAC_BIT_ABORT    3
`define NVAC_BIT_DONE     7
`define NVAC_KEY_FIRST    8'h55
`define NVAC_KEY_SECOND   8'haa
`define NVAC_KEY_GAP      8'h02
`define NVAC_GAP_MAX      8'hff
`define NVAC_RST_BYTE     8'h00
`define NVAC_DEPTH        128
`define NVAC_PWRUP_MS     72
`define NVAC_CLK_KHZ      200000
`define NVAC_WRITE_CYC    16'h0400
`endif

// [verilog/nvac_ctrl.v]
// nonvolatile byte access controller with avalon-mm register slave
`timescale 1ns/1ps
`include "nvac_map.vh"
module nvac_ctrl #(
  parameter [31:0] PWRUP_CYC = `NVAC_PWRUP_MS * `NVAC_CLK_KHZ
) (
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  input  wire        POR_EVENT,
  input  wire        DATA_LOCK,
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  output reg         WRITE_BUSY
);

////////////////////////////////////////////////////////////////////////////////
// storage and registers

reg  [7:0]  mem_ff [0:`NVAC_DEPTH-1];
reg  [7:0]  byte_ff;
reg  [6:0]  index_ff;
reg         en_ff;
reg         wr_ff;
reg         abort_ff;
reg         done_ff;
reg  [1:0]  key_st_ff;
reg  [7:0]  gap_ff;
reg  [15:0] wcnt_ff;
reg  [31:0] pwr_ff;
reg  [6:0]  w_index_ff;
reg  [7:0]  w_byte_ff;
reg  [2:0]  por_sync_ff;
reg         por_seen_ff;
reg         pwr_active_ff;
reg         ack_ff;
reg  [7:0]  nxt_rdata;

localparam [1:0] KEY_IDLE = 2'h0;
localparam [1:0] KEY_ONE  = 2'h1;
localparam [1:0] KEY_TWO  = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// request decode

wire       req;
wire       wr_go;
wire [7:0] wd;
wire       wr_ctl;
wire       sel_unl;
wire       wr_byte;
wire       wr_index;
wire       wr_flag;
wire       rd_strobe;
wire       lock_unused;
wire       keys_ok;
wire       start_ok;
wire       wr_end;

// a request is taken once, on its first cycle; the held cycle is ignored
assign req         = (AVS_READ | AVS_WRITE) & ~ack_ff;
assign wr_go       = AVS_WRITE & ~ack_ff;
assign wd          = AVS_WRITEDATA[7:0];
assign wr_ctl      = wr_go & (AVS_ADDRESS == `NVAC_OFS_CONTROL);
assign sel_unl     = wr_go & (AVS_ADDRESS == `NVAC_OFS_UNLOCK);
assign wr_byte     = wr_go & (AVS_ADDRESS == `NVAC_OFS_BYTE);
assign wr_index    = wr_go & (AVS_ADDRESS == `NVAC_OFS_INDEX);
assign wr_flag     = wr_go & (AVS_ADDRESS == `NVAC_OFS_FLAG);
assign rd_strobe   = wr_ctl & wd[`NVAC_BIT_RD];
// data lock only gates an external programmer, so the cpu path ignores it
assign lock_unused = DATA_LOCK;
// both keys in order and with the fixed spacing must precede the start
assign keys_ok     = (key_st_ff == KEY_TWO) & (gap_ff == `NVAC_KEY_GAP);
assign start_ok    = wr_ctl & wd[`NVAC_BIT_WR] & wd[`NVAC_BIT_EN] & en_ff & ~wr_ff
                     & keys_ok & ~pwr_active_ff;
assign wr_end      = wr_ff & (wcnt_ff == 16'h0000);

////////////////////////////////////////////////////////////////////////////////
// power-on pin synchroniser; compare only the second and third stages

always @(posedge CLK_SYS) begin
  por_sync_ff <= {por_sync_ff[1:0], POR_EVENT};
end

wire por_rise = por_sync_ff[1] & por_sync_ff[2] & ~por_seen_ff;

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    por_seen_ff <= 1'b0;
  end else if (por_sync_ff[1] == por_sync_ff[2]) begin
    por_seen_ff <= por_sync_ff[2];
  end
end

////////////////////////////////////////////////////////////////////////////////
// power-up inhibit timer, restarted by each power-on event

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    pwr_ff <= PWRUP_CYC;
  end else if (por_rise) begin
    pwr_ff <= PWRUP_CYC;
  end else if (pwr_ff != 32'h0000_0000) begin
    pwr_ff <= pwr_ff - 32'h0000_0001;
  end
end

// the inhibit drops one cycle after the count runs out
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    pwr_active_ff <= 1'b1;
  end else if (por_rise) begin
    pwr_active_ff <= 1'b1;
  end else if (pwr_ff == 32'h0000_0000) begin
    pwr_active_ff <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// unlock key tracker: counts cycles between key writes

// spacing counter: restarts at every key write and saturates while waiting
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    gap_ff <= 8'h00;
  end else if (sel_unl) begin
    gap_ff <= 8'h00;
  end else if (key_st_ff != KEY_IDLE && gap_ff != `NVAC_GAP_MAX) begin
    gap_ff <= gap_ff + 8'h01;
  end
end

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    key_st_ff <= KEY_IDLE;
  end else if (sel_unl) begin
    if (wd == `NVAC_KEY_FIRST) begin
      key_st_ff <= KEY_ONE;
    end else if (wd == `NVAC_KEY_SECOND && key_st_ff == KEY_ONE
                 && gap_ff == `NVAC_KEY_GAP) begin
      key_st_ff <= KEY_TWO;
    end else begin
      key_st_ff <= KEY_IDLE;
    end
  end else if (wr_go) begin
    // any other register write breaks the sequence
    key_st_ff <= KEY_IDLE;
  end else if (gap_ff == `NVAC_GAP_MAX) begin
    // a sequence left waiting too long is dropped
    key_st_ff <= KEY_IDLE;
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes, strobes and write cycle

// the read strobe is never stored, so it reads back as zero
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    byte_ff <= `NVAC_RST_BYTE;
  end else if (rd_strobe) begin
    byte_ff <= mem_ff[index_ff];
  end else if (wr_byte) begin
    byte_ff <= wd;
  end
end

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    index_ff <= 7'h00;
  end else if (wr_index) begin
    index_ff <= wd[6:0];
  end
end

// store enable follows software; reset and a power-on event are the only hardware clears
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    en_ff <= 1'b0;
  end else if (por_rise) begin
    en_ff <= 1'b0;
  end else if (wr_ctl) begin
    en_ff <= wd[`NVAC_BIT_EN];
  end
end

// the cycle works on latched copies, so later register writes cannot alter it
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    wr_ff      <= 1'b0;
    wcnt_ff    <= 16'h0000;
    w_index_ff <= 7'h00;
    w_byte_ff  <= `NVAC_RST_BYTE;
  end else if (start_ok) begin
    wr_ff      <= 1'b1;
    wcnt_ff    <= `NVAC_WRITE_CYC;
    w_index_ff <= index_ff;
    w_byte_ff  <= byte_ff;
  end else if (wr_end) begin
    wr_ff <= 1'b0;
  end else if (wr_ff) begin
    wcnt_ff <= wcnt_ff - 16'h0001;
  end
end

// the done flag's set beats a same-cycle software clear
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    done_ff <= 1'b0;
  end else if (wr_end) begin
    done_ff <= 1'b1;
  end else if (wr_flag) begin
    done_ff <= wd[`NVAC_BIT_DONE];
  end
end

// a reset that cuts a running write leaves abort set; the write strobe is
// gone after the first reset cycle, so only a one-cycle reset keeps the flag
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    abort_ff <= wr_ff;
  end else if (wr_ctl) begin
    abort_ff <= wd[`NVAC_BIT_ABORT];
  end
end

always @(posedge CLK_SYS) begin
  if (!SYS_RST && wr_end) begin
    mem_ff[w_index_ff] <= w_byte_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
// avalon-mm slave: one wait state, unmapped offsets read zero

always @* begin
  nxt_rdata = 8'h00;
  case (AVS_ADDRESS)
    `NVAC_OFS_FLAG:    nxt_rdata = {done_ff, 7'h00};
    `NVAC_OFS_BYTE:    nxt_rdata = byte_ff;
    `NVAC_OFS_INDEX:   nxt_rdata = {1'b0, index_ff};
    `NVAC_OFS_CONTROL: nxt_rdata = {4'h0, abort_ff, en_ff, wr_ff, 1'b0};
    `NVAC_OFS_UNLOCK:  nxt_rdata = 8'h00;
    `NVAC_OFS_STATUS:  nxt_rdata = {7'h00, pwr_active_ff};
    default:           nxt_rdata = 8'h00;
  endcase
end

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    ack_ff <= 1'b0;
  end else begin
    ack_ff <= req;
  end
end

// waitrequest stays high while idle, so a master never sees a stale answer
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    AVS_WAITREQUEST <= 1'b1;
  end else begin
    AVS_WAITREQUEST <= ~req;
  end
end

always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    AVS_READDATA <= 32'h0000_0000;
  end else begin
    AVS_READDATA <= {24'h000000, nxt_rdata};
  end
end

// busy includes the start cycle so it rises together with the write strobe
always @(posedge CLK_SYS) begin
  if (SYS_RST) begin
    WRITE_BUSY <= 1'b0;
  end else begin
    WRITE_BUSY <= wr_ff | start_ok;
  end
end

endmodule

// [dv/nvac_monitor.sv]
// port assertions for the nonvolatile access controller
`timescale 1ns/1ps
module nvac_monitor #(parameter [31:0] PWRUP_CYC = 20) (
  input wire        CLK_SYS,
  input wire        SYS_RST,
  input wire [7:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        WRITE_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  reg [31:0] pwr_ff;
  // power-on events are not mirrored; the bench holds that pin low
  always @(posedge CLK_SYS) begin
    if (SYS_RST) pwr_ff <= 32'h0;
    else if (pwr_ff < PWRUP_CYC) pwr_ff <= pwr_ff + 32'h1;
  end
  reg [15:0] busy_cnt_ff;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) busy_cnt_ff <= 16'h0;
    else if (WRITE_BUSY) busy_cnt_ff <= busy_cnt_ff + 16'h1;
    else busy_cnt_ff <= 16'h0;
  end
  sequence rd_of(logic [7:0] a);
    $rose(AVS_READ) && AVS_ADDRESS == a;
  endsequence
  ////////////////////////////////////////
  ack_next_a: assert property ($rose(AVS_READ | AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  ack_short_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("acknowledge longer than one cycle");
  idle_wait_a: assert property (!(AVS_READ | AVS_WRITE) [*2] |-> AVS_WAITREQUEST)
    else $error("acknowledge without request");
  rd_clear_a: assert property (rd_of(8'h9c) |=> !AVS_READDATA[0])
    else $error("read strobe not cleared");
  unlock_zero_a: assert property (rd_of(8'h9d) |=> AVS_READDATA == 32'h0)
    else $error("unlock port not zero");
  wr_bit_a: assert property (rd_of(8'h9c) ##0 WRITE_BUSY |=> AVS_READDATA[1])
    else $error("write strobe low while busy");
  write_len_a: assert property ($fell(WRITE_BUSY) && !$past(SYS_RST) |->
    busy_cnt_ff >= 16'd1017 && busy_cnt_ff <= 16'd1029)
    else $error("write time wrong");
  pwrup_block_a: assert property (pwr_ff < PWRUP_CYC |-> !WRITE_BUSY)
    else $error("write during power-up delay");
endmodule
bind nvac_ctrl nvac_monitor #(.PWRUP_CYC(PWRUP_CYC)) mon (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .WRITE_BUSY(WRITE_BUSY));

// [dv/data_eeprom_access_ctrl_test.sv]
// register-level regression for the nonvolatile access controller
`timescale 1ns/1ps
module data_eeprom_access_ctrl_test;
  logic        clk = 0, rst = 1, lock = 0, rd = 0, wr = 0, wrq, busy;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          err_total = 0, num_checks = 0, cyc = 0;
  nvac_ctrl #(.PWRUP_CYC(32'd40)) dut (.CLK_SYS(clk), .SYS_RST(rst), .POR_EVENT(1'h0),
    .DATA_LOCK(lock), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq), .WRITE_BUSY(busy));
  initial begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // g idle edges before the request; unlock keys must be taken exactly 3 edges apart, which g of 1 gives
  task automatic acc(input logic w, input logic [7:0] a, d, input int g);
    repeat (g) @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    do @(posedge clk); while (wrq !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(0, a, 8'h00, 1);
    chk(q, e);
  endtask
  task automatic store(input logic [7:0] i, d, k1, k2, c, input int g);
    acc(1, 8'h9b, i, 1);
    acc(1, 8'h9a, d, 1);
    acc(1, 8'h9c, c & 8'h04, 1);
    acc(1, 8'h9d, k1, 1);
    acc(1, 8'h9d, k2, g);
    acc(1, 8'h9c, c, 1);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rdc(8'h9c, 32'h0);
    rdc(8'h9d, 32'h0);
    store(8'h03, 8'h11, 8'h55, 8'haa, 8'h06, 1);
    rdc(8'h9c, 32'h04);
    repeat (40) @(posedge clk);
    store(8'h03, 8'h11, 8'h55, 8'haa, 8'h06, 2);
    rdc(8'h9c, 32'h04);
    store(8'h03, 8'h11, 8'haa, 8'h55, 8'h06, 1);
    rdc(8'h9c, 32'h04);
    store(8'h03, 8'h11, 8'h55, 8'haa, 8'h02, 1);
    rdc(8'h9c, 32'h00);
    lock <= 1'h1;
    store(8'h83, 8'ha5, 8'h55, 8'haa, 8'h06, 1);
    rdc(8'h9c, 32'h06);
    acc(1, 8'h9c, 8'h00, 1);
    rdc(8'h9c, 32'h02);
    while (busy !== 1'h0) @(posedge clk);
    rdc(8'h9c, 32'h00);
    rdc(8'h0c, 32'h80);
    repeat (20) @(posedge clk);
    rdc(8'h0c, 32'h80);
    acc(1, 8'h0c, 8'h00, 1);
    rdc(8'h0c, 32'h00);
    acc(1, 8'h9a, 8'h00, 1);
    acc(1, 8'h9b, 8'h03, 1);
    acc(1, 8'h9c, 8'h01, 1);
    rdc(8'h9a, 32'ha5);
    acc(1, 8'h9b, 8'h10, 1);
    rdc(8'h9a, 32'ha5);
    rdc(8'h50, 32'h0);
    store(8'h05, 8'h33, 8'h55, 8'haa, 8'h06, 1);
    repeat (50) @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    rdc(8'h9c, 32'h08);
    give_verdict;
  end
  // a hang ends the run as a counted mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      give_verdict;
    end
  end
endmodule
